/* dv/fci_flash_model.sv */
/* Behavioural byte-wide flash that answers the host's pins.
   Assumes the host changes its pins on clock edges; the model has no clock. */
`timescale 1ns/100ps
module fci_flash_model import fci_pkg::*; #(
    parameter logic [7:0] MAKER_CODE = 8'h3C, // Arbitrary value.
    parameter logic [7:0] PART_CODE  = 8'h5E, // Arbitrary value.
    parameter int         OP_NS      = 3000
) (
    input  fci_pkg::fci_pins_t pins,
    output logic [7:0]         dq
);
    logic [7:0]  mem [16];
    logic [7:0]  stat;
    logic [7:0]  first;
    logic [7:0]  q;
    logic [1:0]  mode;
    logic [15:0] lock;
    logic        mlock;
    logic        busy;
    logic        susp;
    int          left;

    // Wake-up state; a power-down pulse aborts whatever was running.
    task automatic wake();
        mode  = 2'd0;
        stat  = 8'h80;
        first = 8'h00;
        busy  = 1'b0;
        susp  = 1'b0;
    endtask : wake

    task automatic go();
        busy    = 1'b1;
        stat[7] = 1'b0;
        left    = OP_NS / 50;
    endtask : go

    // Second cycles finish a setup; single cycles switch the read mode, clear status, suspend or resume.
    task automatic cmd(input logic [19:0] a, input logic [7:0] d);
        logic [3:0] b;
        logic       er;
        b  = a[19:16];
        er = (first == 8'h20);
        if (first != 8'h00) begin
            mode = 2'd2;
            if (er && d != 8'hD0) stat = stat | 8'h30;
            else if (!pins.program_supply_high) stat = stat | (er ? 8'h28 : 8'h18);
            else if (first != 8'h60) begin
                if (lock[b] && !pins.elevated_override) stat = stat | (er ? 8'h22 : 8'h12);
                else begin
                    mem[b] = er ? 8'hFF : (mem[b] & d);
                    go();
                end
            end else if (!pins.elevated_override && (mlock || d == 8'hF1)) stat = stat | 8'h12;
            else begin
                if (d == 8'h01) lock[b] = 1'b1;
                else if (d == 8'hF1) mlock = 1'b1;
                else if (d == 8'hD0) lock = 16'h0000;
                else stat = stat | 8'h30;
                go();
            end
            first = 8'h00;
        end else begin
            case (d)
                8'hFF: if (!busy || susp) mode = 2'd0;
                8'h90: mode = 2'd1;
                8'h70: mode = 2'd2;
                8'h50: if (!susp) stat = stat & 8'hC5;
                8'hB0: if (busy) susp = 1'b1;
                8'hD0: if (susp) susp = 1'b0;
                default: first = d;
            endcase
            if (d == 8'hB0 || d == 8'hD0) stat[7:6] = {susp, susp};
        end
    endtask : cmd

    initial begin
        wake();
        q     = 8'h00;
        lock  = 16'h0000;
        mlock = 1'b0;
        for (int i = 0; i < 16; i++) mem[i] = {4'hA, 4'(i)};
    end
    always @(negedge pins.reset_powerdown_n) wake();

    // Deselection does not stop a running operation; suspend pauses it and a power-down pulse aborts it.
    always #50 if (busy && !susp) begin
        if (left == 0) begin
            busy    = 1'b0;
            stat[7] = 1'b1;
        end else left = left - 1;
    end

    // Whichever of write enable and chip select rises first closes a write.
    always @(posedge pins.we_n) if (!pins.ce_n) cmd(pins.addr, pins.dq_out);
    always @(posedge pins.ce_n) if (!pins.we_n) cmd(pins.addr, pins.dq_out);

    // The output byte is captured once per fall of output enable or select.
    always @(negedge pins.oe_n or negedge pins.ce_n) if (!pins.oe_n && !pins.ce_n) begin
        if (mode == 2'd2) q = stat;
        else if (mode == 2'd0) q = mem[pins.addr[19:16]];
        else case (pins.addr[1:0])
            2'd0: q = MAKER_CODE;
            2'd1: q = PART_CODE;
            2'd2: q = {7'h00, lock[pins.addr[19:16]]};
            default: q = {7'h00, mlock};
        endcase
    end

    // Released pins show the inverse byte, so stale data can never pass.
    assign dq = (!pins.ce_n && !pins.oe_n && pins.reset_powerdown_n) ? q : ~q;
endmodule : fci_flash_model

/* dv/fci_host_asserts.sv */
/* Concurrent checks on the flash host's pins and software port.
   Bound into every fci_host instance and sees only its ports. */
`timescale 1ns/100ps
module fci_host_asserts import fci_pkg::*; #(
    parameter int STROBE_CYCLES = FCI_STROBE_CYCLES,
    parameter int GAP_CYCLES    = FCI_GAP_CYCLES
) (
    input wire logic                           sys_clk,
    input wire logic                           rst_b,
    input wire logic [7:0]                     reg_addr,
    input wire logic [31:0]                    reg_wdata,
    input wire logic                           reg_wr,
    input wire logic                           reg_rd,
    input wire logic [31:0]                    reg_rdata,
    input wire fci_pkg::fci_pins_t             flash_pins,
    input wire logic [fci_pkg::FCI_DATA_W-1:0] flash_dq_in
);
    localparam int S_M1 = STROBE_CYCLES - 1;
    localparam int G_M1 = GAP_CYCLES - 1;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // Short names for the pins under watch.
    wire ce_n = flash_pins.ce_n;
    wire oe_n = flash_pins.oe_n;
    wire we_n = flash_pins.we_n;
    wire pd_n = flash_pins.reset_powerdown_n;
    wire ctrl_wr = reg_wr && reg_addr == FCI_REG_CTRL;

    sequence s_we_hold;
        (!we_n && !ce_n && flash_pins.dq_oe && $stable(flash_pins.dq_out)) throughout (##S_M1 1'b1);
    endsequence
    sequence s_oe_hold;
        (!oe_n && !ce_n && !flash_pins.dq_oe) throughout (##S_M1 1'b1);
    endsequence
    property p_write_strobe; $fell(we_n) |-> s_we_hold ##1 (we_n && !ce_n && $stable(flash_pins.dq_out)); endproperty
    a_write_strobe: assert property (p_write_strobe) else $error("write strobe shape wrong");
    property p_read_strobe; $fell(oe_n) |-> s_oe_hold ##1 (oe_n && !ce_n); endproperty
    a_read_strobe: assert property (p_read_strobe) else $error("read strobe shape wrong");
    property p_oe_we; oe_n || we_n; endproperty
    a_oe_we: assert property (p_oe_we) else $error("output and write enable low together");
    property p_float; flash_pins.dq_oe |-> oe_n; endproperty
    a_float: assert property (p_float) else $error("host drives data while flash outputs");
    property p_ce_setup; $fell(ce_n) |-> we_n && oe_n; endproperty
    a_ce_setup: assert property (p_ce_setup) else $error("strobe low at select");
    property p_gap; $rose(ce_n) |-> (ce_n && we_n && oe_n) throughout (##G_M1 1'b1); endproperty
    a_gap: assert property (p_gap) else $error("select gap too short");
    property p_addr; !ce_n |-> $stable(flash_pins.addr); endproperty
    a_addr: assert property (p_addr) else $error("address moved while selected");
    property p_pd; $fell(pd_n) |-> (!pd_n && ce_n) [*4] ##1 pd_n; endproperty
    a_pd: assert property (p_pd) else $error("power-down pulse length wrong");
    property p_ctrl;
        $changed({flash_pins.elevated_override, flash_pins.program_supply_high}) |-> $past(ctrl_wr) || $past(ctrl_wr, 2);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("override pins moved without a write");
endmodule : fci_host_asserts

bind fci_host fci_host_asserts #(.STROBE_CYCLES(STROBE_CYCLES), .GAP_CYCLES(GAP_CYCLES)) i_asserts (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_pins(flash_pins), .flash_dq_in(flash_dq_in)
);

/* dv/test_fci_host.sv */
/* Self-checking bench: software port tasks order the host, a flash model answers.
   Assumes the host's default strobe, gap and wake counts. */
`timescale 1ns/100ps
module test_fci_host import fci_pkg::*;;
    localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value.
    localparam logic [7:0] PART  = 8'h5E; // Arbitrary value.
    logic        sys_clk   = 1'b0;
    logic        rst_b     = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] w;
    fci_pins_t   flash_pins;
    logic [7:0]  flash_dq_in;
    logic [7:0]  b;
    int          n_mismatch = 0;
    int          n_checks   = 0;
    int          cycles     = 0;
    logic [19:0] id_a [4] = '{20'h0_0000, 20'h0_0001, 20'h3_0002, 20'h0_0003};
    logic [7:0]  id_e [4] = '{MAKER, PART, 8'h01, 8'h00};

    fci_host i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_pins(flash_pins), .flash_dq_in(flash_dq_in));
    fci_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) i_flash (.pins(flash_pins), .dq(flash_dq_in));

    initial forever #12.5 sys_clk = ~sys_clk;
    // A hang ends the run as a mismatch.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
    endtask : do_reset
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    // Orders are only given once the host reports idle, never refused.
    task automatic idle(output logic [31:0] s);
        s = 32'h0000_0001;
        for (int i = 0; i < 40 && s[FCI_ST_BUSY] !== 1'b0; i++) rd(FCI_REG_STATUS, s);
    endtask : idle
    task automatic fop(input logic [19:0] a, input logic [3:0] c, output logic [7:0] r);
        logic [31:0] s;
        wr(FCI_REG_ADDR, {12'h000, a});
        wr(FCI_REG_CMD, {28'h000_0000, c});
        idle(s);
        r = s[15:8];
    endtask : fop
    task automatic wait_rdy(output logic [7:0] r);
        r = 8'h00;
        for (int i = 0; i < 30 && r[7] !== 1'b1; i++) fop(20'h0_0000, FCI_OP_READ_STAT, r);
    endtask : wait_rdy
    task automatic arr(input logic [19:0] a, output logic [7:0] r);
        fop(a, FCI_OP_READ_ARRAY, r);
        fop(a, FCI_OP_READ, r);
    endtask : arr

    // Main sequence: each step's expected byte follows from the command set.
    initial begin
        do_reset();
        rd(8'h20, w);
        chk("unmapped read", 8'h00, w[7:0]);
        wr(FCI_REG_CMD, 32'h0000_000F);
        rd(FCI_REG_STATUS, w);
        chk("bad op flag", 8'h02, w[7:0]);
        wr(FCI_REG_CTRL, 32'h0000_0004);
        fop(20'h3_0000, FCI_OP_READ, b);
        chk("array after power-up", 8'hA3, b);
        wait_rdy(b);
        chk("status after power-up", 8'h80, b);
        fop(20'h3_0000, FCI_OP_ERASE, b);
        fop(20'h3_0000, FCI_OP_READ_ARRAY, b);
        fop(20'h3_0000, FCI_OP_READ, b);
        chk("status while erasing", 8'h00, b);
        wait_rdy(b);
        chk("status after erase", 8'h80, b);
        arr(20'h3_0000, b);
        chk("erased byte", 8'hFF, b);
        wr(FCI_REG_WDATA, 32'h0000_005A);
        fop(20'h3_0000, FCI_OP_WRITE, b);
        wait_rdy(b);
        wr(FCI_REG_WDATA, 32'h0000_000F);
        fop(20'h3_0000, FCI_OP_WRITE_ALT, b);
        wait_rdy(b);
        arr(20'h3_0000, b);
        chk("written byte", 8'h0A, b);
        fop(20'h3_0000, FCI_OP_LOCK_BLOCK, b);
        wait_rdy(b);
        for (int i = 0; i < 4; i++) begin
            fop(id_a[i], FCI_OP_READ_ID, b);
            chk("identifier byte", id_e[i], b);
        end
        fop(20'h3_0000, FCI_OP_ERASE, b);
        wait_rdy(b);
        chk("locked erase", 8'hA2, b);
        fop(20'h4_0000, FCI_OP_ERASE, b);
        fop(20'h4_0000, FCI_OP_SUSPEND, b);
        fop(20'h0_0000, FCI_OP_CLEAR_STAT, b);
        wait_rdy(b);
        chk("suspended status", 8'hE2, b);
        fop(20'h0_0000, FCI_OP_RESUME, b);
        fop(20'h0_0000, FCI_OP_READ_STAT, b);
        chk("resumed status", 8'h22, b);
        fop(20'h0_0000, FCI_OP_CLEAR_STAT, b);
        wait_rdy(b);
        chk("cleared status", 8'h80, b);
        wr(FCI_REG_CTRL, 32'h0000_0006);
        fop(20'h3_0000, FCI_OP_ERASE, b);
        wait_rdy(b);
        chk("override erase", 8'h80, b);
        fop(20'h0_0000, FCI_OP_LOCK_MAST, b);
        wr(FCI_REG_CTRL, 32'h0000_0004);
        fop(20'h0_0000, FCI_OP_UNLOCK_ALL, b);
        wait_rdy(b);
        chk("guarded unlock", 8'h92, b);
        wr(FCI_REG_CTRL, 32'h0000_0006);
        fop(20'h0_0000, FCI_OP_CLEAR_STAT, b);
        fop(20'h0_0000, FCI_OP_UNLOCK_ALL, b);
        wait_rdy(b);
        fop(20'h3_0002, FCI_OP_READ_ID, b);
        chk("block lock cleared", 8'h00, b);
        fop(20'h0_0003, FCI_OP_READ_ID, b);
        chk("master lock set", 8'h01, b);
        do_reset();
        fop(20'h5_0000, FCI_OP_ERASE, b);
        wait_rdy(b);
        chk("erase without supply", 8'hA8, b);
        wr(FCI_REG_CTRL, 32'h0000_0001);
        idle(w);
        fop(20'h5_0000, FCI_OP_READ, b);
        chk("array after wake", 8'hA5, b);
        wait_rdy(b);
        chk("status after wake", 8'h80, b);
        final_report();
    end
endmodule : test_fci_host

/* hw/fci_host.sv */
/*
 * Host-side controller for an asynchronous byte-wide flash: turns
 * software orders into correctly ordered command bus cycles on the
 * flash pins and reports the bytes it reads back.
 * Assumes the flash data pins are sampled synchronously to sys_clk and
 * that software polls the status register; there is no interrupt.
 */
`timescale 1ns/100ps
module fci_host #(
    parameter int STROBE_CYCLES = fci_pkg::FCI_STROBE_CYCLES,
    parameter int GAP_CYCLES    = fci_pkg::FCI_GAP_CYCLES,
    parameter int WAKE_CYCLES   = fci_pkg::FCI_WAKE_CYCLES
) (
    input  wire logic                               sys_clk,
    input  wire logic                               rst_b,
    input  wire logic [7:0]                         reg_addr,
    input  wire logic [31:0]                        reg_wdata,
    input  wire logic                               reg_wr,
    input  wire logic                               reg_rd,
    output logic      [31:0]                        reg_rdata,
    output fci_pkg::fci_pins_t                      flash_pins,
    input  wire logic [fci_pkg::FCI_DATA_W-1:0]     flash_dq_in
);
    import fci_pkg::*;

    // ----------------------
    // Software-visible state
    // ----------------------
    logic [FCI_ADDR_W-1:0] op_addr;
    logic [FCI_DATA_W-1:0] op_wdata;
    logic [FCI_DATA_W-1:0] last_read;
    logic                  bad_op;
    logic                  refused;
    logic                  elevated;
    logic                  supply_high;
    fci_op_t               cur_op;

    // ----------------------
    // Sequencer state
    // ----------------------
    fci_state_t            state;
    fci_state_t            next_state;
    logic [7:0]            cnt;
    logic [7:0]            next_cnt;
    logic                  phase;
    logic                  pd_wake;

    // Register decode: strobes qualified by address.
    wire wr_cmd    = reg_wr && (reg_addr == FCI_REG_CMD);
    wire wr_addr   = reg_wr && (reg_addr == FCI_REG_ADDR);
    wire wr_wdata  = reg_wr && (reg_addr == FCI_REG_WDATA);
    wire wr_status = reg_wr && (reg_addr == FCI_REG_STATUS);
    wire wr_ctrl   = reg_wr && (reg_addr == FCI_REG_CTRL);
    wire idle      = (state == FCI_S_IDLE);
    wire busy      = !idle;

    // Operation decode: only listed command bytes can ever be produced,
    // an unknown operation code sets bad_op and is dropped before it reaches the pins.
    wire [3:0] req_op   = reg_wdata[3:0];
    wire       req_ok   = (req_op <= FCI_OP_READ);
    wire       start_op = wr_cmd && idle && req_ok;
    wire       start_pd = wr_ctrl && reg_wdata[FCI_CTRL_PD] && idle;

    // ----------------------
    // Per-phase cycle description
    // ----------------------
    fci_kind_t       kind0;
    fci_kind_t       kind1;
    logic [7:0]      byte0;
    logic [7:0]      byte1;

    // Table of the command sequences; second phase carries either a
    // confirm or lock byte, the user data byte, or a read of the chosen address.
    always_comb begin
        kind0 = FCI_K_WRITE;
        kind1 = FCI_K_NONE;
        byte0 = FCI_C_READ_ARRAY;
        byte1 = FCI_C_READ_ARRAY;
        case (cur_op)
            FCI_OP_READ_ARRAY: byte0 = FCI_C_READ_ARRAY;
            FCI_OP_READ_ID: begin
                byte0 = FCI_C_READ_ID;
                kind1 = FCI_K_READ;
            end
            FCI_OP_READ_STAT: begin
                byte0 = FCI_C_READ_STAT;
                kind1 = FCI_K_READ;
            end
            FCI_OP_CLEAR_STAT: byte0 = FCI_C_CLEAR_STAT;
            FCI_OP_ERASE: begin
                byte0 = FCI_C_ERASE;
                byte1 = FCI_C_CONFIRM;
                kind1 = FCI_K_WRITE;
            end
            FCI_OP_WRITE, FCI_OP_WRITE_ALT: begin
                byte0 = (cur_op == FCI_OP_WRITE) ? FCI_C_WRITE : FCI_C_WRITE_ALT;
                byte1 = op_wdata;
                kind1 = FCI_K_WRITE;
            end
            FCI_OP_SUSPEND: byte0 = FCI_C_SUSPEND;
            FCI_OP_RESUME:  byte0 = FCI_C_CONFIRM;
            FCI_OP_LOCK_BLOCK, FCI_OP_LOCK_MAST, FCI_OP_UNLOCK_ALL: begin
                byte0 = FCI_C_LOCK_SETUP;
                kind1 = FCI_K_WRITE;
                byte1 = (cur_op == FCI_OP_LOCK_BLOCK) ? FCI_C_LOCK_BLOCK :
                        (cur_op == FCI_OP_LOCK_MAST)  ? FCI_C_LOCK_MAST  : FCI_C_CONFIRM;
            end
            FCI_OP_READ:    kind0 = FCI_K_READ;
            default:        kind0 = FCI_K_READ;
        endcase
    end

    // Selection for the phase in flight.
    wire fci_kind_t ph_kind  = phase ? kind1 : kind0;
    wire [7:0]      ph_byte  = phase ? byte1 : byte0;
    wire            ph_write = (ph_kind == FCI_K_WRITE);
    wire [7:0]      strobe_n = 8'(STROBE_CYCLES - 1);
    wire [7:0]      gap_n    = 8'(GAP_CYCLES - 1);
    wire [7:0]      rp_n     = 8'(FCI_RP_LOW_CYCLES - 1);
    wire [7:0]      wake_n   = 8'(WAKE_CYCLES - 1);
    wire            cnt_done = (cnt == 8'h00);
    wire            more     = !phase && (kind1 != FCI_K_NONE);

    // ----------------------
    // Bus-cycle sequencer
    // ----------------------
    // Every cycle walks setup, strobe, hold and gap; the gap returns chip
    // select high so each read sees a fresh status latch.
    always_comb begin
        next_state = state;
        next_cnt   = cnt_done ? 8'h00 : cnt - 8'h01;
        case (state)
            FCI_S_IDLE: begin
                next_cnt = 8'h00;
                if (start_pd) begin
                    next_state = FCI_S_PD;
                    next_cnt   = rp_n;
                end else if (start_op) begin
                    next_state = FCI_S_SETUP;
                end
            end
            FCI_S_SETUP: begin
                next_state = FCI_S_STROBE;
                next_cnt   = strobe_n;
            end
            FCI_S_STROBE: if (cnt_done) next_state = FCI_S_HOLD;
            FCI_S_HOLD: begin
                next_state = FCI_S_GAP;
                next_cnt   = gap_n;
            end
            FCI_S_GAP: if (cnt_done) next_state = more ? FCI_S_SETUP : FCI_S_IDLE;
            FCI_S_PD: begin
                if (cnt_done && !pd_wake) next_cnt = wake_n;
                else if (cnt_done)        next_state = FCI_S_IDLE;
            end
            default: next_state = FCI_S_IDLE;
        endcase
    end

    // State, counter and phase registers.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state   <= FCI_S_IDLE;
            cnt     <= 8'h00;
            phase   <= 1'b0;
            pd_wake <= 1'b0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            if (start_op)                                  phase <= 1'b0;
            else if (state == FCI_S_GAP && cnt_done && more) phase <= 1'b1;
            if (state == FCI_S_PD && cnt_done)             pd_wake <= 1'b1;
            else if (state != FCI_S_PD)                    pd_wake <= 1'b0;
        end
    end

    // ----------------------
    // Pin drivers
    // ----------------------
    // Write enable rises in the strobe-to-hold step while chip select and
    // data stay put one more cycle, so the flash latches on write enable.
    // Only one of write and output enable is ever low, chosen by the
    // kind of the phase.
    // Strobes follow the present state, so phase and operation are settled
    // before select falls and the byte never changes inside a cycle.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            flash_pins <= '{default: '0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_powerdown_n: 1'b1};
        end else begin
            flash_pins.addr                <= op_addr;
            flash_pins.ce_n                <= !(state inside {FCI_S_SETUP, FCI_S_STROBE, FCI_S_HOLD});
            flash_pins.we_n                <= !(state == FCI_S_STROBE && ph_write);
            flash_pins.oe_n                <= !(state == FCI_S_STROBE && !ph_write);
            flash_pins.dq_out              <= ph_byte;
            flash_pins.dq_oe               <= ph_write &&
                                              (state inside {FCI_S_SETUP, FCI_S_STROBE, FCI_S_HOLD});
            flash_pins.reset_powerdown_n   <= !(next_state == FCI_S_PD && !(pd_wake || (state == FCI_S_PD && cnt_done)));
            flash_pins.elevated_override   <= elevated;
            flash_pins.program_supply_high <= supply_high;
        end
    end

    // ----------------------
    // Software registers and read capture
    // ----------------------
    // Sticky flags: a new event wins over a clear in the same cycle.
    // Orders arriving while busy are dropped rather than queued, which
    // keeps the pin sequence of the running operation intact.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            op_addr     <= '0;
            op_wdata    <= '0;
            last_read   <= '0;
            bad_op      <= 1'b0;
            refused     <= 1'b0;
            elevated    <= 1'b0;
            supply_high <= 1'b0;
            cur_op      <= FCI_OP_READ_ARRAY;
        end else begin
            if (wr_addr && idle)  op_addr  <= reg_wdata[FCI_ADDR_W-1:0];
            if (wr_wdata && idle) op_wdata <= reg_wdata[FCI_DATA_W-1:0];
            if (start_op)         cur_op   <= fci_op_t'(req_op);
            if (wr_ctrl) begin
                elevated    <= reg_wdata[FCI_CTRL_HH];
                supply_high <= reg_wdata[FCI_CTRL_VPP];
            end
            // Sample at the end of the output-enable pulse.
            if (state == FCI_S_STROBE && cnt_done && !ph_write) last_read <= flash_dq_in;
            if (wr_cmd && !req_ok)                        bad_op  <= 1'b1;
            else if (wr_status && reg_wdata[FCI_ST_BAD_OP]) bad_op  <= 1'b0;
            if ((wr_cmd || wr_addr || wr_wdata || (wr_ctrl && reg_wdata[FCI_CTRL_PD])) && busy) refused <= 1'b1;
            else if (wr_status && reg_wdata[FCI_ST_REFUSED]) refused <= 1'b0;
        end
    end

    // Read mux, answered one cycle after the read strobe.
    wire [31:0] status_word = {16'h0000, last_read, 5'b0_0000, refused, bad_op, busy};
    wire [31:0] ctrl_word   = {29'h0000_0000, supply_high, elevated, 1'b0};
    wire [31:0] rd_mux      = (reg_addr == FCI_REG_CMD)    ? {28'h000_0000, cur_op} :
                              (reg_addr == FCI_REG_ADDR)   ? {12'h000, op_addr} :
                              (reg_addr == FCI_REG_WDATA)  ? {24'h00_0000, op_wdata} :
                              (reg_addr == FCI_REG_STATUS) ? status_word :
                              (reg_addr == FCI_REG_CTRL)   ? ctrl_word : 32'h0000_0000;

    // Read data register; zero outside the answer cycle.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) reg_rdata <= 32'h0000_0000;
        else        reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end

endmodule : fci_host

/* shared/fci_pkg.sv */
/*
 * Shared definitions for the flash command host: register map of the
 * software port, operation codes, flash command bytes, timing counts,
 * the pin bundle and the bus-cycle states.
 * Assumes a 40 MHz system clock and an asynchronous byte-wide flash.
 */
package fci_pkg;

    // ----------------------
    // Widths and timing
    // ----------------------
    localparam int FCI_ADDR_W        = 20;
    localparam int FCI_DATA_W        = 8;
    localparam int FCI_CLK_PERIOD_NS = 25;
    localparam int FCI_RP_LOW_NS     = 100;
    localparam int FCI_RP_LOW_CYCLES = (FCI_RP_LOW_NS + FCI_CLK_PERIOD_NS - 1) / FCI_CLK_PERIOD_NS;
    localparam int FCI_STROBE_CYCLES = 4;
    localparam int FCI_GAP_CYCLES    = 2;
    localparam int FCI_WAKE_CYCLES   = 8;

    // ----------------------
    // Software register map (byte offsets) and field positions
    // ----------------------
    localparam logic [7:0] FCI_REG_CMD    = 8'h00;
    localparam logic [7:0] FCI_REG_ADDR   = 8'h04;
    localparam logic [7:0] FCI_REG_WDATA  = 8'h08;
    localparam logic [7:0] FCI_REG_STATUS = 8'h0C;
    localparam logic [7:0] FCI_REG_CTRL   = 8'h10;
    localparam int FCI_ST_BUSY    = 0;
    localparam int FCI_ST_BAD_OP  = 1;
    localparam int FCI_ST_REFUSED = 2;
    localparam int FCI_ST_RD_LSB  = 8;
    localparam int FCI_CTRL_PD    = 0;
    localparam int FCI_CTRL_HH    = 1;
    localparam int FCI_CTRL_VPP   = 2;

    // ----------------------
    // Flash command bytes
    // ----------------------
    localparam logic [7:0] FCI_C_READ_ARRAY = 8'hFF;
    localparam logic [7:0] FCI_C_READ_ID    = 8'h90;
    localparam logic [7:0] FCI_C_READ_STAT  = 8'h70;
    localparam logic [7:0] FCI_C_CLEAR_STAT = 8'h50;
    localparam logic [7:0] FCI_C_ERASE      = 8'h20;
    localparam logic [7:0] FCI_C_CONFIRM    = 8'hD0;
    localparam logic [7:0] FCI_C_WRITE      = 8'h40;
    localparam logic [7:0] FCI_C_WRITE_ALT  = 8'h10;
    localparam logic [7:0] FCI_C_SUSPEND    = 8'hB0;
    localparam logic [7:0] FCI_C_LOCK_SETUP = 8'h60;
    localparam logic [7:0] FCI_C_LOCK_BLOCK = 8'h01;
    localparam logic [7:0] FCI_C_LOCK_MAST  = 8'hF1;

    // ----------------------
    // Operations that software orders through the command register
    // ----------------------
    typedef enum logic [3:0] {
        FCI_OP_READ_ARRAY = 4'h0,
        FCI_OP_READ_ID    = 4'h1,
        FCI_OP_READ_STAT  = 4'h2,
        FCI_OP_CLEAR_STAT = 4'h3,
        FCI_OP_ERASE      = 4'h4,
        FCI_OP_WRITE      = 4'h5,
        FCI_OP_WRITE_ALT  = 4'h6,
        FCI_OP_SUSPEND    = 4'h7,
        FCI_OP_RESUME     = 4'h8,
        FCI_OP_LOCK_BLOCK = 4'h9,
        FCI_OP_LOCK_MAST  = 4'hA,
        FCI_OP_UNLOCK_ALL = 4'hB,
        FCI_OP_READ       = 4'hC
    } fci_op_t;

    // Kind of bus cycle in one phase of an operation.
    typedef enum logic [1:0] {
        FCI_K_NONE  = 2'd0,
        FCI_K_WRITE = 2'd1,
        FCI_K_READ  = 2'd2
    } fci_kind_t;

    // Bus-cycle sequencer states.
    typedef enum logic [5:0] {
        FCI_S_IDLE   = 6'b00_0001,
        FCI_S_SETUP  = 6'b00_0010,
        FCI_S_STROBE = 6'b00_0100,
        FCI_S_HOLD   = 6'b00_1000,
        FCI_S_GAP    = 6'b01_0000,
        FCI_S_PD     = 6'b10_0000
    } fci_state_t;

    // Pins driven toward the flash.
    typedef struct packed {
        logic [FCI_ADDR_W-1:0] addr;
        logic                  ce_n;
        logic                  oe_n;
        logic                  we_n;
        logic [FCI_DATA_W-1:0] dq_out;
        logic                  dq_oe;
        logic                  reset_powerdown_n;
        logic                  elevated_override;
        logic                  program_supply_high;
    } fci_pins_t;

endpackage : fci_pkg
